// >>> hw/bcm_regs.vh
// constants for the burst counter and mailbox port logic
`ifndef BCM_REGS_VH
`define BCM_REGS_VH
`define BCM_AW 18
`define BCM_ONES 18'h3ffff
`define BCM_ZERO 18'h00000
`define BCM_STEP1 18'h00001
`define BCM_STEP2 18'h00002
`define BCM_MBOX_R 18'h3ffff
`define BCM_MBOX_L 18'h3fffe
// bus register byte offsets
`define BCM_OFS_CTRL 8'h00
`define BCM_OFS_STAT 8'h04
`define BCM_OFS_CNT_L 8'h08
`define BCM_OFS_CNT_R 8'h0c
`define BCM_OFS_MSK_L 8'h10
`define BCM_OFS_MSK_R 8'h14
`define BCM_OFS_MIR_L 8'h18
`define BCM_OFS_MIR_R 8'h1c
`define BCM_CTRL_RST 1'h1
`define BCM_HRESP_OKAY 1'h0
`define BCM_WORD_ZERO 32'h00000000
`endif

// >>> hw/bcm_port_counter.v
// burst address counter with mask and mirror for one port
`timescale 1ns/1ns
`include "bcm_regs.vh"
module bcm_port_counter (
  // clock and reset
  input wire hclk,
  input wire rst_n,
  // control pins
  input wire counter_or_mask_select,
  input wire counter_clear_n,
  input wire address_strobe_n,
  input wire count_enable_n,
  input wire port_enabled,
  input wire [`BCM_AW-1:0] addr_in,
  // state and readback
  output reg [`BCM_AW-1:0] count_reg,
  output reg [`BCM_AW-1:0] mask_reg,
  output reg [`BCM_AW-1:0] mirror_reg,
  output reg count_wrap_flag_n,
  output reg [`BCM_AW-1:0] addr_out_reg,
  output reg addr_oe_n_reg,
  output reg data_float_reg
);
  wire [`BCM_AW-1:0] filled;
  wire [`BCM_AW-1:0] step;
  wire [`BCM_AW-1:0] summed;
  wire [`BCM_AW-1:0] inc_val;
  wire [`BCM_AW-1:0] cleared;

  // masked bits read as ones so the carry skips past them
  assign filled = count_reg | ~mask_reg;
  assign step = mask_reg[0] ? `BCM_STEP1 : `BCM_STEP2;
  assign summed = filled + step;
  assign inc_val = (filled == `BCM_ONES) ? mirror_reg :
    ((count_reg & ~mask_reg) | (summed & mask_reg));
  assign cleared = count_reg & ~mask_reg;

  // operation decode, all on the clock edge; chip selects only gate the readback data float
  always @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= `BCM_ZERO;
      mask_reg <= `BCM_ONES;
      mirror_reg <= `BCM_ZERO;
      count_wrap_flag_n <= 1'b1;
      addr_out_reg <= `BCM_ZERO;
      addr_oe_n_reg <= 1'b1;
      data_float_reg <= 1'b0;
    end else begin
      addr_oe_n_reg <= 1'b1;
      data_float_reg <= 1'b0;
      if (counter_or_mask_select) begin
        if (!counter_clear_n) begin
          count_reg <= cleared;
          mirror_reg <= cleared;
          count_wrap_flag_n <= 1'b1;
        end else if (!address_strobe_n && !count_enable_n) begin
          count_reg <= addr_in;
          mirror_reg <= addr_in;
          count_wrap_flag_n <= 1'b1;
        end else if (!address_strobe_n) begin
          addr_out_reg <= count_reg;
          addr_oe_n_reg <= 1'b0;
          data_float_reg <= port_enabled;
        end else if (!count_enable_n) begin
          count_reg <= inc_val;
          count_wrap_flag_n <= ((inc_val | ~mask_reg) != `BCM_ONES);
        end
        // clear, strobe and enable high: counter, mirror, mask and wrap flag hold, readback drive released
      end else begin
        if (!counter_clear_n) begin
          mask_reg <= `BCM_ONES;
          count_wrap_flag_n <= 1'b1;
        end else if (!address_strobe_n && !count_enable_n) begin
          mask_reg <= addr_in;
          count_wrap_flag_n <= 1'b1;
        end else if (!address_strobe_n) begin
          addr_out_reg <= mask_reg;
          addr_oe_n_reg <= 1'b0;
          data_float_reg <= port_enabled;
        end
        // clear and strobe high in mask mode is reserved: no change
      end
    end
  end
endmodule // bcm_port_counter

// >>> hw/bcm_dual_port_ctl.v
// dual-port control: two burst counters, mailbox flags, bus registers
`timescale 1ns/1ns
`include "bcm_regs.vh"
module bcm_dual_port_ctl (
  // clock and resets
  input wire hclk,
  input wire hresetn,
  input wire global_reset_n,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // left port pins
  input wire counter_or_mask_select_l,
  input wire counter_clear_n_l,
  input wire address_strobe_n_l,
  input wire count_enable_n_l,
  input wire chip_select_low_n_l,
  input wire chip_select_high_l,
  input wire [3:0] byte_lane_select_n_l,
  input wire read_not_write_l,
  input wire [`BCM_AW-1:0] addr_in_l,
  output wire [`BCM_AW-1:0] addr_out_l,
  output wire addr_oe_n_l,
  output wire data_float_l,
  output wire [`BCM_AW-1:0] array_addr_l,
  output wire count_wrap_flag_n_l,
  output reg mailbox_flag_n_l,
  // right port pins
  input wire counter_or_mask_select_r,
  input wire counter_clear_n_r,
  input wire address_strobe_n_r,
  input wire count_enable_n_r,
  input wire chip_select_low_n_r,
  input wire chip_select_high_r,
  input wire [3:0] byte_lane_select_n_r,
  input wire read_not_write_r,
  input wire [`BCM_AW-1:0] addr_in_r,
  output wire [`BCM_AW-1:0] addr_out_r,
  output wire addr_oe_n_r,
  output wire data_float_r,
  output wire [`BCM_AW-1:0] array_addr_r,
  output wire count_wrap_flag_n_r,
  output reg mailbox_flag_n_r
);
  // reset and port qualification
  wire rst_n;
  wire en_l;
  wire en_r;
  wire lane_l;
  wire lane_r;
  wire wr_l;
  wire wr_r;
  wire rd_l;
  wire rd_r;
  // counter, mask and mirror state of each port
  wire [`BCM_AW-1:0] cnt_l;
  wire [`BCM_AW-1:0] cnt_r;
  wire [`BCM_AW-1:0] msk_l;
  wire [`BCM_AW-1:0] msk_r;
  wire [`BCM_AW-1:0] mir_l;
  wire [`BCM_AW-1:0] mir_r;
  // mailbox address hits and events
  wire [`BCM_AW-1:0] eff_l;
  wire [`BCM_AW-1:0] eff_r;
  wire l_at_mbox_l;
  wire l_at_mbox_r;
  wire r_at_mbox_l;
  wire r_at_mbox_r;
  wire set_l;
  wire set_r;
  wire clr_l;
  wire clr_r;
  reg mbox_l_next;
  reg mbox_r_next;
  // bus slave state
  reg ctrl_mbox_en_reg;
  reg ctrl_next;
  reg wr_pend_reg;
  reg wr_pend_next;
  reg [7:0] wr_ofs_reg;
  reg [31:0] rd_next;
  reg [31:0] hrdata_next;
  wire [3:0] stat_bits;
  wire addr_phase;
  wire wr_commit;

  // either reset source clears the counters and mailbox flags, no clock needed
  assign rst_n = hresetn & global_reset_n;

  // port enable and byte-lane qualification
  assign en_l = ~chip_select_low_n_l & chip_select_high_l;
  assign en_r = ~chip_select_low_n_r & chip_select_high_r;
  assign lane_l = ~(&byte_lane_select_n_l);
  assign lane_r = ~(&byte_lane_select_n_r);

  // mailbox compare address: pins on a strobe, else the running counter; array address is always the counter
  assign eff_l = address_strobe_n_l ? cnt_l : addr_in_l;
  assign eff_r = address_strobe_n_r ? cnt_r : addr_in_r;
  assign array_addr_l = cnt_l;
  assign array_addr_r = cnt_r;

  // enabled accesses with at least one byte lane, split by direction
  assign wr_l = en_l & lane_l & ~read_not_write_l;
  assign wr_r = en_r & lane_r & ~read_not_write_r;
  assign rd_l = en_l & lane_l & read_not_write_l;
  assign rd_r = en_r & lane_r & read_not_write_r;

  // which mailbox word each port is touching this cycle
  assign l_at_mbox_l = (eff_l == `BCM_MBOX_L);
  assign l_at_mbox_r = (eff_l == `BCM_MBOX_R);
  assign r_at_mbox_l = (eff_r == `BCM_MBOX_L);
  assign r_at_mbox_r = (eff_r == `BCM_MBOX_R);

  // only the peer's write sets, only the owner's read clears; a port touching
  // the wrong word leaves the flag alone
  assign set_r = ctrl_mbox_en_reg & wr_l & l_at_mbox_r;
  assign set_l = ctrl_mbox_en_reg & wr_r & r_at_mbox_l;
  assign clr_r = rd_r & r_at_mbox_r;
  assign clr_l = rd_l & l_at_mbox_l;

  // both counters run from the combined reset, so a pin reset and a bus
  // reset leave the ports in the same state
  bcm_port_counter u_left (
    .hclk(hclk),
    .rst_n(rst_n),
    .counter_or_mask_select(counter_or_mask_select_l),
    .counter_clear_n(counter_clear_n_l),
    .address_strobe_n(address_strobe_n_l),
    .count_enable_n(count_enable_n_l),
    .port_enabled(en_l),
    .addr_in(addr_in_l),
    .count_reg(cnt_l),
    .mask_reg(msk_l),
    .mirror_reg(mir_l),
    .count_wrap_flag_n(count_wrap_flag_n_l),
    .addr_out_reg(addr_out_l),
    .addr_oe_n_reg(addr_oe_n_l),
    .data_float_reg(data_float_l)
  );

  bcm_port_counter u_right (
    .hclk(hclk),
    .rst_n(rst_n),
    .counter_or_mask_select(counter_or_mask_select_r),
    .counter_clear_n(counter_clear_n_r),
    .address_strobe_n(address_strobe_n_r),
    .count_enable_n(count_enable_n_r),
    .port_enabled(en_r),
    .addr_in(addr_in_r),
    .count_reg(cnt_r),
    .mask_reg(msk_r),
    .mirror_reg(mir_r),
    .count_wrap_flag_n(count_wrap_flag_n_r),
    .addr_out_reg(addr_out_r),
    .addr_oe_n_reg(addr_oe_n_r),
    .data_float_reg(data_float_r)
  );

  // mailbox flag next values; a set on the same edge as the owner's read wins,
  // so a message posted while the old one is being fetched is never lost
  always @* begin
    mbox_l_next = mailbox_flag_n_l;
    if (set_l) begin
      mbox_l_next = 1'b0;
    end else if (clr_l) begin
      mbox_l_next = 1'b1;
    end
  end

  // right flag next value, same priority as the left one
  always @* begin
    mbox_r_next = mailbox_flag_n_r;
    if (set_r) begin
      mbox_r_next = 1'b0;
    end else if (clr_r) begin
      mbox_r_next = 1'b1;
    end
  end

  // left flag register: flow-through, no extra stage behind the access edge
  always @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      mailbox_flag_n_l <= 1'b1;
    end else begin
      mailbox_flag_n_l <= mbox_l_next;
    end
  end

  // right flag register
  always @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      mailbox_flag_n_r <= 1'b1;
    end else begin
      mailbox_flag_n_r <= mbox_r_next;
    end
  end

  // bus slave address map, one aligned word per register:
  //   00 control: bit 0 lets peer writes set the mailbox flags
  //   04 status: wrap right, wrap left, mailbox right, mailbox left
  //   08 / 0c counter left / right, read only
  //   10 / 14 mask left / right, read only
  //   18 / 1c mirror left / right, read only
  // unmapped offsets read zero and ignore writes; hsize is not decoded,
  // so a narrow access still moves the whole word
  assign addr_phase = hsel & htrans[1] & hready;

  // the one writable field lands at the edge that ends the data phase
  assign wr_commit = wr_pend_reg & (wr_ofs_reg == `BCM_OFS_CTRL);

  // status word: both wrap flags over both mailbox flags, all active low
  assign stat_bits = {count_wrap_flag_n_r, count_wrap_flag_n_l, mailbox_flag_n_r,
    mailbox_flag_n_l};

  // read mux; unmapped offsets read as zero
  always @* begin
    rd_next = `BCM_WORD_ZERO;
    case (haddr[7:0])
      `BCM_OFS_CTRL: begin
        rd_next[0] = ctrl_mbox_en_reg;
      end
      `BCM_OFS_STAT: begin
        rd_next[3:0] = stat_bits;
      end
      `BCM_OFS_CNT_L: begin
        rd_next[`BCM_AW-1:0] = cnt_l;
      end
      `BCM_OFS_CNT_R: begin
        rd_next[`BCM_AW-1:0] = cnt_r;
      end
      `BCM_OFS_MSK_L: begin
        rd_next[`BCM_AW-1:0] = msk_l;
      end
      `BCM_OFS_MSK_R: begin
        rd_next[`BCM_AW-1:0] = msk_r;
      end
      `BCM_OFS_MIR_L: begin
        rd_next[`BCM_AW-1:0] = mir_l;
      end
      `BCM_OFS_MIR_R: begin
        rd_next[`BCM_AW-1:0] = mir_r;
      end
      default: begin
        rd_next = `BCM_WORD_ZERO;
      end
    endcase
  end

  // read data is fetched in the address phase so it stands the whole data phase
  always @* begin
    hrdata_next = hrdata;
    if (addr_phase) begin
      if (hwrite) begin
        hrdata_next = `BCM_WORD_ZERO;
      end else begin
        hrdata_next = rd_next;
      end
    end
  end

  // control bit next value; only the control word is writable
  always @* begin
    ctrl_next = ctrl_mbox_en_reg;
    if (wr_commit) begin
      ctrl_next = hwdata[0];
    end
  end

  // a write is pending for exactly the one data phase that follows its address
  always @* begin
    wr_pend_next = 1'b0;
    if (addr_phase && hwrite) begin
      wr_pend_next = 1'b1;
    end
  end

  // read data register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `BCM_WORD_ZERO;
    end else begin
      hrdata <= hrdata_next;
    end
  end

  // zero wait states: the slave never stretches a transfer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // every transfer is answered okay, unmapped ones included
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= `BCM_HRESP_OKAY;
    end else begin
      hresp <= `BCM_HRESP_OKAY;
    end
  end

  // write pending flag for the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
    end
  end

  // offset captured only in an address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ofs_reg <= 8'h00;
    end else begin
      if (addr_phase) begin
        wr_ofs_reg <= haddr[7:0];
      end
    end
  end

  // control register; only the bus reset touches it, so a pin reset does not
  // re-enable mailbox setting behind software's back
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_mbox_en_reg <= `BCM_CTRL_RST;
    end else begin
      ctrl_mbox_en_reg <= ctrl_next;
    end
  end
endmodule // bcm_dual_port_ctl

// >>> bench/bcm_checker.sv
// concurrent checks on the dual-port control block pins
`timescale 1ns/1ns
module bcm_checker (
  // clock and resets
  input logic hclk, hresetn, global_reset_n,
  // bus answer
  input logic hreadyout, hresp,
  // left port
  input logic counter_or_mask_select_l, counter_clear_n_l, address_strobe_n_l,
  input logic count_enable_n_l, chip_select_low_n_l, chip_select_high_l,
  input logic read_not_write_l, addr_oe_n_l, count_wrap_flag_n_l, mailbox_flag_n_l,
  input logic [3:0] byte_lane_select_n_l,
  input logic [17:0] addr_in_l, array_addr_l,
  // right port
  input logic chip_select_low_n_r, chip_select_high_r, read_not_write_r,
  input logic address_strobe_n_r, mailbox_flag_n_r,
  input logic [3:0] byte_lane_select_n_r,
  input logic [17:0] addr_in_r, array_addr_r
);
  // left control nibble: mode, clear, strobe, enable
  wire [3:0] ctl = {counter_or_mask_select_l, counter_clear_n_l, address_strobe_n_l,
    count_enable_n_l};
  // effective access address follows the counter while the strobe is high
  wire [17:0] ea_l = address_strobe_n_l ? array_addr_l : addr_in_l;
  wire [17:0] ea_r = address_strobe_n_r ? array_addr_r : addr_in_r;
  wire lw = !chip_select_low_n_l && chip_select_high_l && byte_lane_select_n_l != 4'hf
    && !read_not_write_l && ea_l == 18'h3ffff;
  wire rr = !chip_select_low_n_r && chip_select_high_r && byte_lane_select_n_r != 4'hf
    && read_not_write_r && ea_r == 18'h3ffff;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn || !global_reset_n);
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  chk_load_count: assert property (ctl == 4'hc |=> array_addr_l == $past(addr_in_l))
    else $error("counter load missed");
  chk_hold_count: assert property (ctl == 4'hf |=> $stable(array_addr_l))
    else $error("counter moved on hold");
  chk_mask_steady: assert property (!ctl[3] |=> $stable(array_addr_l))
    else $error("counter moved in mask mode");
  chk_readback_drive: assert property (ctl == 4'hd |=> !addr_oe_n_l)
    else $error("readback not driven");
  chk_clear_wrap: assert property (!ctl[2] |=> count_wrap_flag_n_l)
    else $error("wrap flag low after clear");
  chk_mbox_set: assert property (lw |=> !mailbox_flag_n_r)
    else $error("mailbox flag not set");
  chk_mbox_clear: assert property (rr && !lw |=> mailbox_flag_n_r)
    else $error("mailbox flag not cleared");
  chk_reset_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    !global_reset_n |-> mailbox_flag_n_l && mailbox_flag_n_r && count_wrap_flag_n_l
    && array_addr_l == 18'h00000) else $error("global reset state wrong");
  // main scenarios reached
  cov_load: cover property (ctl == 4'hc);
  cov_wrap: cover property ($fell(count_wrap_flag_n_l));
  cov_mbox: cover property (lw);
endmodule // bcm_checker
bind bcm_dual_port_ctl bcm_checker chk_i (.*);

// >>> bench/bcm_port_master.sv
// controller model driving one port's counter and access pins
`timescale 1ns/1ns
module bcm_port_master (
  // clock and command
  input logic hclk,
  input logic [2:0] op,
  input logic [1:0] acc,
  input logic [17:0] val,
  // port pins
  output logic cm, clr_n, ads_n, en_n, cs0_n, cs1, rnw,
  output logic [3:0] be_n,
  output logic [17:0] a
);
  // hold, load, inc, readback, clear, mask load, mask clear, mask readback
  // mask mode never raises the strobe with clear high
  localparam logic [3:0] tbl [8] = '{4'hf, 4'hc, 4'he, 4'hd, 4'hb, 4'h4, 4'h1, 4'h5};
  logic [17:0] last = 18'h0;
  assign {cm, clr_n, ads_n, en_n} = tbl[op];
  // one lane only, the least generous access that still counts
  assign {cs0_n, cs1, be_n, rnw} = acc != 2'd0 ? {2'b01, 4'he, acc == 2'd2} : 7'h7d;
  // released lines show the inverse of the last value, not a stale copy
  assign a = (op == 3'd1 || op == 3'd5 || acc != 2'd0) ? val : ~last;
  always @(posedge hclk) begin
    last <= a;
  end
endmodule // bcm_port_master

// >>> bench/test_bcm_dual_port_ctl.sv
// self-checking bench for the dual-port control block
`timescale 1ns/1ns
module test_bcm_dual_port_ctl;
  logic hclk = 0, hresetn = 0, global_reset_n = 0, hsel = 1, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'd2;
  logic [2:0] op [2] = '{3'd0, 3'd0};
  logic [1:0] acc [2] = '{2'd0, 2'd0};
  logic [17:0] val [2] = '{18'h0, 18'h0};
  int n_mismatch = 0, compares = 0;
  wire [31:0] hrdata;
  wire hreadyout, hresp;
  wire counter_or_mask_select_l, counter_clear_n_l, address_strobe_n_l, count_enable_n_l;
  wire chip_select_low_n_l, chip_select_high_l, read_not_write_l, addr_oe_n_l, data_float_l;
  wire count_wrap_flag_n_l, mailbox_flag_n_l;
  wire [3:0] byte_lane_select_n_l;
  wire [17:0] addr_in_l, addr_out_l, array_addr_l;
  wire counter_or_mask_select_r, counter_clear_n_r, address_strobe_n_r, count_enable_n_r;
  wire chip_select_low_n_r, chip_select_high_r, read_not_write_r, addr_oe_n_r, data_float_r;
  wire count_wrap_flag_n_r, mailbox_flag_n_r;
  wire [3:0] byte_lane_select_n_r;
  wire [17:0] addr_in_r, addr_out_r, array_addr_r;
  wire hready = hreadyout;
  wire [1:0] mbf = {mailbox_flag_n_r, mailbox_flag_n_l};
  initial forever #4 hclk = ~hclk;
  bcm_dual_port_ctl DUT (.*);
  bcm_port_master pm_l (.hclk, .op(op[0]), .acc(acc[0]), .val(val[0]),
    .cm(counter_or_mask_select_l), .clr_n(counter_clear_n_l), .ads_n(address_strobe_n_l),
    .en_n(count_enable_n_l), .cs0_n(chip_select_low_n_l), .cs1(chip_select_high_l),
    .rnw(read_not_write_l), .be_n(byte_lane_select_n_l), .a(addr_in_l));
  bcm_port_master pm_r (.hclk, .op(op[1]), .acc(acc[1]), .val(val[1]),
    .cm(counter_or_mask_select_r), .clr_n(counter_clear_n_r), .ads_n(address_strobe_n_r),
    .en_n(count_enable_n_r), .cs0_n(chip_select_low_n_r), .cs1(chip_select_high_r),
    .rnw(read_not_write_r), .be_n(byte_lane_select_n_r), .a(addr_in_r));
  task automatic ck(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      n_mismatch++;
    end
  endtask
  task end_sim;
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait for the slave's ready at a rising edge
  task wrdy;
    int i;
    i = 0;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++i < 50);
    if (i >= 50) begin
      n_mismatch++;
      end_sim;
    end
  endtask
  // one single word transfer; read data lands in rd
  task ahb(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wrdy;
    htrans <= 2'b00;
    hwdata <= d;
    wrdy;
    rd = hrdata;
  endtask
  // new port command from the next edge, taken one edge later
  task pt(input int s, input logic [2:0] o, input logic [1:0] c, input logic [17:0] v);
    @(posedge hclk);
    op[s] <= o;
    acc[s] <= c;
    val[s] <= v;
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    global_reset_n <= 1;
    ahb(0, 32'h10, 0);
    ck("mask_l", 32'h3ffff, rd);
    ahb(1, 32'h08, 32'h5);
    ahb(0, 32'h08, 0);
    ck("count_ro", 0, rd);
    ahb(0, 32'h40, 0);
    ck("unmapped", 0, rd);
    ahb(0, 32'h00, 0);
    ck("ctrl", 1, rd);
    // wrap walk: mask 3f, start 8
    pt(0, 5, 0, 18'h3f);
    pt(0, 1, 0, 18'h8);
    pt(0, 2, 0, 0);
    #1 ck("load", 8, array_addr_l);
    repeat (55) @(posedge hclk);
    #1 ck("top", 32'h3f, array_addr_l);
    ck("wrap_low", 0, count_wrap_flag_n_l);
    pt(0, 0, 0, 0);
    #1 ck("mirror", 8, array_addr_l);
    ck("wrap_high", 1, count_wrap_flag_n_l);
    // clear keeps the masked upper bits
    pt(0, 1, 0, 18'h1c5);
    pt(0, 4, 0, 0);
    pt(0, 2, 0, 0);
    #1 ck("clear", 32'h1c0, array_addr_l);
    pt(0, 0, 0, 0);
    #1 ck("inc", 32'h1c1, array_addr_l);
    ahb(0, 32'h18, 0);
    ck("mirror_clr", 32'h1c0, rd);
    // masked lsb steps by two, then both readbacks
    pt(0, 5, 0, 18'h3e);
    pt(0, 1, 0, 18'h4);
    pt(0, 2, 0, 0);
    pt(0, 3, 2, 0);
    #1 ck("by_two", 6, array_addr_l);
    pt(0, 7, 0, 0);
    #1 ck("readback", 6, addr_out_l);
    ck("rb_float", 2'b10, {data_float_l, addr_oe_n_l});
    pt(0, 6, 0, 0);
    #1 ck("mask_rb", 32'h3e, addr_out_l);
    pt(0, 0, 0, 0);
    ahb(0, 32'h10, 0);
    ck("mask_clr", 32'h3ffff, rd);
    // mailbox of each side: own write, peer write, peer read, owner read
    for (int s = 0; s < 2; s++) begin
      pt(s, 1, 1, {17'h1ffff, s[0]});
      pt(1 - s, 1, 1, {17'h1ffff, s[0]});
      #1 ck("own_write", 1, mbf[s]);
      pt(1 - s, 1, 2, {17'h1ffff, s[0]});
      #1 ck("peer_write", 0, mbf[s]);
      pt(s, 1, 2, {17'h1ffff, s[0]});
      #1 ck("peer_read", 0, mbf[s]);
      pt(1 - s, 0, 0, 0);
      #1 ck("owner_read", 1, mbf[s]);
      pt(s, 0, 0, 0);
    end
    // right readback of the counter left by the mailbox walk
    pt(1, 3, 0, 0);
    pt(1, 0, 0, 0);
    #1 ck("rb_r", 32'h3ffff, addr_out_r);
    ck("oe_r", 2'b00, {data_float_r, addr_oe_n_r});
    ck("cnt_r", 32'h3ffff, array_addr_r);
    // global reset dropped between edges
    pt(0, 1, 1, 18'h3ffff);
    pt(0, 0, 0, 0);
    #3 global_reset_n <= 0;
    #2 ck("g_count", 0, array_addr_l);
    ck("g_flags", 4'hf, {mbf, count_wrap_flag_n_l, count_wrap_flag_n_r});
    @(posedge hclk);
    global_reset_n <= 1;
    ahb(0, 32'h10, 0);
    ck("g_mask", 32'h3ffff, rd);
    ahb(0, 32'h18, 0);
    ck("g_mirror", 0, rd);
    end_sim;
  end
endmodule // test_bcm_dual_port_ctl
